// ===== rtl/alu_and_barrel_shifter.sv
// alu and barrel shifter datapath with an axi4-lite register front end
//
// Overview of operation
// - codes 0000,0001,1100,1110 give and, xor, or, and-not of operands.
// - 0010 is one minus two, 0011 two minus one, 0100 sum.
// - 0101,0110,0111 are add, subtract, reverse subtract with carry.
// - 1000 to 1011 test only; result register is never written.
// - 1101 passes operand two, 1111 its inverse; operand one ignored.
// - logical ops keep v, take shifter carry, z on zero, n bit 31.
// - arithmetic ops set v on signed overflow, c from the adder carry out, bit 32.
// - arithmetic ops set z on zero result, n from bit 31.
// - shift amount is a 5-bit field or the low byte of a register.
// - left shift fills zeros; last bit out at top is carry.
// - left shift by zero passes value and keeps old carry.
// - logical right shift fills vacated high bits with zeros.
// - immediate right shift field zero means shift 32, carry bit 31.
// - arithmetic right shift fills with copies of bit 31.
// - immediate arithmetic field zero means 32: all bits are bit 31.
// - rotate right reinserts low bits at the top end.
// - immediate rotate field zero rotates one through carry.
// - register shift with zero low byte passes value, old carry.
// - register shifts of 32 or more follow the extended shift table.
// - 8-bit immediate rotated right by twice the 4-bit field.
`timescale 1ns/1ps
module alu_and_barrel_shifter (
	input  wire logic                               aclk,    // 10 MHz clock
	input  wire logic                               aresetn, // sync reset
	input  wire logic [alu_shift_pkg::ADDR_W-1:0]   awaddr,  // write addr
	input  wire logic [2:0]                         awprot,  // unused
	input  wire logic                               awvalid, // addr valid
	output logic                                    awready, // addr taken
	input  wire logic [alu_shift_pkg::DATA_W-1:0]   wdata,   // write data
	input  wire logic [3:0]                         wstrb,   // byte lanes
	input  wire logic                               wvalid,  // data valid
	output logic                                    wready,  // data taken
	output logic [1:0]                              bresp,   // write resp
	output logic                                    bvalid,  // resp valid
	input  wire logic                               bready,  // resp taken
	input  wire logic [alu_shift_pkg::ADDR_W-1:0]   araddr,  // read addr
	input  wire logic [2:0]                         arprot,  // unused
	input  wire logic                               arvalid, // addr valid
	output logic                                    arready, // addr taken
	output logic [alu_shift_pkg::DATA_W-1:0]        rdata,   // read data
	output logic [1:0]                              rresp,   // read resp
	output logic                                    rvalid,  // data valid
	input  wire logic                               rready   // data taken
);
	import alu_shift_pkg::*;

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic [DATA_W-1:0] operand_one;
	logic [DATA_W-1:0] shift_source;
	logic [DATA_W-1:0] shift_count;
	control_type       control;
	flags_type         status_word;
	logic [DATA_W-1:0] result;
	logic              write_back;
	logic [ADDR_W-1:0] aw_addr;
	logic              aw_full;
	logic [DATA_W-1:0] w_data;
	logic [3:0]        w_strb;
	logic              w_full;

	// merge a write under byte strobes
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] data, input logic [3:0] strb);
		logic [31:0] m;
		m = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				m[i*8 +: 8] = data[i*8 +: 8];
			end
		end
		return m;
	endfunction

	// returns {carry, value}
	function automatic logic [32:0] barrel(input logic [31:0] v,
		input shift_kind_type kind, input logic [7:0] amt,
		input logic imm_form, input logic cin);
		logic [32:0]        left_wide;
		logic [32:0]        right_wide;
		logic signed [32:0] sign_wide;
		logic [63:0]        rot_wide;
		logic [4:0]         n;
		logic [32:0]        o;
		n          = amt[4:0];
		left_wide  = {1'b0, v} << n;
		right_wide = {v, 1'b0} >> n;
		sign_wide  = $signed({v, 1'b0}) >>> n;
		rot_wide   = {v, v} >> n;
		o   = {cin, v};
		if (amt == 8'h00) begin
			if (imm_form) begin
				case (kind)
				shift_right_logical: o = {v[SIGN_BIT], 32'h0};
				arith_shift_right:   o = {33{v[SIGN_BIT]}};
				rotate_right:        o = {v[0], cin, v[31:1]};
				default:             o = {cin, v};
				endcase
			end
		end else if (amt < 8'd32) begin
			case (kind)
			shift_left_logical:  o = left_wide;
			shift_right_logical:
				o = {right_wide[0], right_wide[32:1]};
			arith_shift_right:
				o = {sign_wide[0], sign_wide[32:1]};
			rotate_right:
				o = {rot_wide[31], rot_wide[31:0]};
			default:             o = {cin, v};
			endcase
		end else begin
			// only a register count reaches 32 or more
			case (kind)
			shift_left_logical:
				o = (amt == 8'd32) ? {v[0], 32'h0} : 33'h0;
			shift_right_logical:
				o = (amt == 8'd32) ? {v[SIGN_BIT], 32'h0} : 33'h0;
			arith_shift_right:
				o = {33{v[SIGN_BIT]}};
			rotate_right:
				o = (n == 5'h0) ? {v[SIGN_BIT], v}
					: {rot_wide[31], rot_wide[31:0]};
			default:
				o = {cin, v};
			endcase
		end
		return o;
	endfunction

	function automatic logic is_arith(input opcode_type op);
		return (op[3:1] == 3'b001) || (op[3:2] == 2'b01) ||
			(op[3:1] == 3'b101);
	endfunction

	// returns {overflow, carry, value} of x + y + cin
	function automatic logic [33:0] adder(input logic [31:0] x,
		input logic [31:0] y, input logic cin);
		logic [32:0] s;
		logic        ov;
		s  = {1'b0, x} + {1'b0, y} + {32'h0, cin};
		ov = (x[SIGN_BIT] == y[SIGN_BIT]) && (s[SIGN_BIT] != x[SIGN_BIT]);
		return {ov, s};
	endfunction

	// second operand
	wire [7:0]  count_now   = control.reg_shift ? shift_count[7:0]
		: {3'h0, control.shift_amount};
	wire [32:0] shifted     = barrel(shift_source, control.shift_kind,
		count_now, !control.reg_shift, status_word.c);
	wire [4:0]  imm_turn    = {control.imm_rotate, 1'b0};
	wire [63:0] imm_wide    = {24'h0, control.imm_value, 24'h0,
		control.imm_value} >> imm_turn;
	wire        imm_carry   = (control.imm_rotate == 4'h0) ? status_word.c
		: imm_wide[SIGN_BIT];
	wire [31:0] operand_two = control.use_imm ? imm_wide[31:0]
		: shifted[31:0];
	wire        shift_carry = control.use_imm ? imm_carry : shifted[32];

	// adder inputs: the second operand of a subtract is inverted
	wire        carry_op  = (control.opcode == add_with_carry) ||
		(control.opcode == subtract_with_carry) ||
		(control.opcode == reverse_subtract_carry);
	wire        swap_op   = (control.opcode == reverse_subtract) ||
		(control.opcode == reverse_subtract_carry);
	wire        sub_op    = (control.opcode == op_sub) ||
		(control.opcode == reverse_subtract) ||
		(control.opcode == subtract_with_carry) ||
		(control.opcode == reverse_subtract_carry) ||
		(control.opcode == subtract_compare);
	wire [31:0] add_x     = swap_op ? operand_two : operand_one;
	wire [31:0] add_y_raw = swap_op ? operand_one : operand_two;
	wire [31:0] add_y     = sub_op ? ~add_y_raw : add_y_raw;
	wire        add_cin   = carry_op ? status_word.c : sub_op;
	wire [33:0] sum       = adder(add_x, add_y, add_cin);

	wire        arith_op  = is_arith(control.opcode);
	logic [31:0] alu_value;
	always_comb begin
		case (control.opcode)
		op_and, and_test:  alu_value = operand_one & operand_two;
		xor_op, xor_test:  alu_value = operand_one ^ operand_two;
		or_op:             alu_value = operand_one | operand_two;
		and_not_clear:     alu_value = operand_one & ~operand_two;
		op_move:           alu_value = operand_two;
		move_inverted:     alu_value = ~operand_two;
		default:           alu_value = sum[31:0];
		endcase
	end

	// tests leave the result register alone
	wire        writes_dest = (control.opcode[3:2] != 2'b10);
	wire        zero_now    = (alu_value == 32'h0);
	flags_type  next_flags;
	assign next_flags.n = alu_value[SIGN_BIT];
	assign next_flags.z = zero_now;
	assign next_flags.c = arith_op ? sum[32] : shift_carry;
	assign next_flags.v = arith_op ? sum[33] : status_word.v;
	// a program-counter destination leaves the flags alone here
	wire        flags_go = control.set_flags && !control.dest_is_pc;

	// register bus
	wire        do_write  = aw_full && w_full && !bvalid;
	wire        execute   = do_write && (aw_addr == EXECUTE_ADDR) &&
		w_strb[0] && w_data[EXECUTE_BIT];
	wire        wr_known  = (aw_addr == OPERAND_ONE_ADDR) ||
		(aw_addr == SHIFT_SOURCE_ADDR) || (aw_addr == SHIFT_COUNT_ADDR) ||
		(aw_addr == CONTROL_ADDR) || (aw_addr == STATUS_WORD_ADDR) ||
		(aw_addr == RESULT_ADDR) || (aw_addr == OUTCOME_ADDR) ||
		(aw_addr == EXECUTE_ADDR);
	wire [31:0] status_rd = {status_word, 28'h0};
	wire [31:0] status_wr = merge(status_rd, w_data, w_strb);
	logic [31:0] read_mux;
	logic        read_ok;
	always_comb begin
		read_ok = 1'b1;
		case (araddr)
		OPERAND_ONE_ADDR:  read_mux = operand_one;
		SHIFT_SOURCE_ADDR: read_mux = shift_source;
		SHIFT_COUNT_ADDR:  read_mux = shift_count;
		CONTROL_ADDR:      read_mux = {5'h0, control[26:0]};
		STATUS_WORD_ADDR:  read_mux = status_rd;
		RESULT_ADDR:       read_mux = result;
		OUTCOME_ADDR:      read_mux = {31'h0, write_back};
		EXECUTE_ADDR:      read_mux = REG_RESET;
		default: begin
			read_mux = REG_RESET;
			read_ok  = 1'b0;
		end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready <= 1'b1;
			wready  <= 1'b1;
			aw_full <= 1'b0;
			w_full  <= 1'b0;
			aw_addr <= '0;
			w_data  <= '0;
			w_strb  <= '0;
			bvalid  <= 1'b0;
			bresp   <= RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				awready <= 1'b0;
				aw_full <= 1'b1;
				aw_addr <= awaddr;
			end
			if (wvalid && wready) begin
				wready <= 1'b0;
				w_full <= 1'b1;
				w_data <= wdata;
				w_strb <= wstrb;
			end
			if (do_write) begin
				aw_full <= 1'b0;
				w_full  <= 1'b0;
				bvalid  <= 1'b1;
				bresp   <= wr_known ? RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid && bready) begin
				bvalid  <= 1'b0;
				awready <= 1'b1;
				wready  <= 1'b1;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b1;
			rvalid  <= 1'b0;
			rdata   <= REG_RESET;
			rresp   <= RESP_OKAY;
		end else if (arvalid && arready) begin
			arready <= 1'b0;
			rvalid  <= 1'b1;
			rdata   <= read_mux;
			rresp   <= read_ok ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid && rready) begin
			rvalid  <= 1'b0;
			arready <= 1'b1;
		end
	end

	wire wr_on = do_write;
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			operand_one  <= REG_RESET;
			shift_source <= REG_RESET;
			shift_count  <= REG_RESET;
			control      <= control_type'(REG_RESET);
			status_word  <= '0;
			result       <= REG_RESET;
			write_back   <= 1'b0;
		end else begin
			if (wr_on && aw_addr == OPERAND_ONE_ADDR)
				operand_one <= merge(operand_one, w_data, w_strb);
			if (wr_on && aw_addr == SHIFT_SOURCE_ADDR)
				shift_source <= merge(shift_source, w_data, w_strb);
			if (wr_on && aw_addr == SHIFT_COUNT_ADDR)
				shift_count <= merge(shift_count, w_data, w_strb);
			if (wr_on && aw_addr == CONTROL_ADDR)
				control <= control_type'(merge({5'h0, control[26:0]},
					w_data, w_strb) & 32'h07ff_ffff);
			// execution updates win over a software flag write
			if (execute && flags_go)
				status_word <= next_flags;
			else if (wr_on && aw_addr == STATUS_WORD_ADDR)
				status_word <= status_wr[31:FLAG_LSB];
			if (execute) begin
				write_back <= writes_dest;
				if (writes_dest)
					result <= alu_value;
			end
		end
	end

	AST_AND_OP: assert property (control.opcode == op_and |->
		alu_value == (operand_one & operand_two))
		else $error("and result wrong");
	AST_REV_SUB: assert property (control.opcode == reverse_subtract |->
		alu_value == 32'(operand_two - operand_one))
		else $error("reverse subtract wrong");
	AST_SUB_CARRY: assert property (control.opcode == subtract_with_carry |->
		alu_value == 32'(operand_one + ~operand_two +
		{31'h0, status_word.c}))
		else $error("subtract with carry wrong");
	AST_TEST_KEEP: assert property (execute && !writes_dest |=>
		result == $past(result) && !write_back)
		else $error("test op wrote result");
	AST_MOVE_INV: assert property (control.opcode == move_inverted |->
		alu_value == ~operand_two)
		else $error("move inverted wrong");
	AST_LOGIC_V: assert property (execute && flags_go && !arith_op |=>
		status_word.v == $past(status_word.v) &&
		status_word.c == $past(shift_carry))
		else $error("logical flags wrong");
	AST_ARITH_FLAGS: assert property (execute && flags_go && arith_op |=>
		status_word.z == ($past(alu_value) == 32'h0) &&
		status_word.n == $past(alu_value[SIGN_BIT]))
		else $error("arith z or n wrong");
	AST_RIGHT32: assert property (!control.use_imm && !control.reg_shift &&
		control.shift_kind == shift_right_logical &&
		control.shift_amount == 5'h0 |->
		operand_two == 32'h0 && shift_carry == shift_source[SIGN_BIT])
		else $error("immediate right shift 32 wrong");
	AST_ROT_EXTEND: assert property (!control.use_imm && !control.reg_shift &&
		control.shift_kind == rotate_right &&
		control.shift_amount == 5'h0 |->
		operand_two == {status_word.c, shift_source[31:1]})
		else $error("rotate extend wrong");
	AST_REG_ZERO: assert property (!control.use_imm && control.reg_shift &&
		shift_count[7:0] == 8'h00 |->
		operand_two == shift_source && shift_carry == status_word.c)
		else $error("zero register shift wrong");
	AST_BRESP: assert property (do_write |=> bvalid [*1] ##0
		(bresp == ($past(wr_known) ? RESP_OKAY : RESP_SLVERR)))
		else $error("write response wrong");

	COV_EXEC_ARITH: cover property (execute && arith_op && flags_go);
	COV_EXEC_TEST: cover property (execute && !writes_dest);
	COV_REG_BIG: cover property (control.reg_shift && count_now > 8'd32);
	COV_READ: cover property (rvalid && rready);
endmodule

// ===== rtl/alu_shift_pkg.sv
// shared constants, types and register map for the alu and barrel shifter
package alu_shift_pkg;
	localparam int unsigned DATA_W        = 32;
	localparam int unsigned ADDR_W        = 8;
	localparam int unsigned SIGN_BIT      = 31;
	localparam int unsigned IMM_SHIFT_MAX = 31;
	localparam int unsigned WORD_BITS     = 32;

	localparam logic [ADDR_W-1:0] OPERAND_ONE_ADDR  = 8'h00;
	localparam logic [ADDR_W-1:0] SHIFT_SOURCE_ADDR = 8'h04;
	localparam logic [ADDR_W-1:0] SHIFT_COUNT_ADDR  = 8'h08;
	localparam logic [ADDR_W-1:0] CONTROL_ADDR      = 8'h0c;
	localparam logic [ADDR_W-1:0] STATUS_WORD_ADDR  = 8'h10;
	localparam logic [ADDR_W-1:0] RESULT_ADDR       = 8'h14;
	localparam logic [ADDR_W-1:0] OUTCOME_ADDR      = 8'h18;
	localparam logic [ADDR_W-1:0] EXECUTE_ADDR      = 8'h1c;

	localparam logic [DATA_W-1:0] REG_RESET    = 32'h0000_0000;
	localparam int unsigned       FLAG_LSB     = 28;
	localparam int unsigned       EXECUTE_BIT  = 0;
	localparam logic [1:0]        RESP_OKAY    = 2'h0;
	localparam logic [1:0]        RESP_SLVERR  = 2'h2;

	typedef enum logic [3:0] {
		op_and                 = 4'h0,
		xor_op                 = 4'h1,
		op_sub                 = 4'h2,
		reverse_subtract       = 4'h3,
		op_add                 = 4'h4,
		add_with_carry         = 4'h5,
		subtract_with_carry    = 4'h6,
		reverse_subtract_carry = 4'h7,
		and_test               = 4'h8,
		xor_test               = 4'h9,
		subtract_compare       = 4'ha,
		add_compare            = 4'hb,
		or_op                  = 4'hc,
		op_move                = 4'hd,
		and_not_clear          = 4'he,
		move_inverted          = 4'hf
	} opcode_type;

	typedef enum logic [1:0] {
		shift_left_logical  = 2'h0,
		shift_right_logical = 2'h1,
		arith_shift_right   = 2'h2,
		rotate_right        = 2'h3
	} shift_kind_type;

	typedef struct packed {
		logic [4:0]     reserved;
		logic           dest_is_pc;
		logic           set_flags;
		logic [3:0]     imm_rotate;
		logic [7:0]     imm_value;
		logic           use_imm;
		logic           reg_shift;
		logic [4:0]     shift_amount;
		shift_kind_type shift_kind;
		opcode_type     opcode;
	} control_type;

	typedef struct packed {
		logic n;
		logic z;
		logic c;
		logic v;
	} flags_type;
endpackage

// ===== verification/alu_and_barrel_shifter_test.sv
// self-checking bench: axi4-lite driver, reference model, random ops
`timescale 1ns/1ps
module alu_and_barrel_shifter_test;
	import alu_shift_pkg::*;
	logic        aclk;
	logic        aresetn = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic [3:0]  wstrb = 4'hf;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
	logic        arvalid = 1'b0, rready = 1'b0;
	logic        awready, wready, bvalid, arready, rvalid;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	int          fails = 0;
	int          checks = 0;
	logic [31:0] seed = 32'h0000_005f;
	logic [31:0] exp_res = 32'h0;
	logic [7:0]  cnt_tbl [8] = '{8'h00, 8'h01, 8'h1f, 8'h20, 8'h21, 8'h40,
		8'h60, 8'hff};

	alu_and_barrel_shifter DUT (.aclk(aclk), .aresetn(aresetn),
		.awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
		.wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arprot(3'h0), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
		.rready(rready));

	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end

	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic wrap_up();
		$display("checks=%0d fails=%0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	initial begin
		#(60000 * 100);
		fails++;
		wrap_up();
	end

	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr  <= a;
		wdata   <= d;
		wstrb   <= s;
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (awvalid && awready) awvalid <= 1'b0;
			if (wvalid && wready) wvalid <= 1'b0;
		end while (!bvalid && n < 200);
		if (n >= 200) fails++;
		bready <= 1'b0;
		check({30'h0, bresp}, {30'h0, er});
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d,
		input logic [1:0] er);
		int n;
		n = 0;
		@(posedge aclk);
		araddr  <= a;
		arvalid <= 1'b1;
		rready  <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (arvalid && arready) arvalid <= 1'b0;
		end while (!rvalid && n < 200);
		if (n >= 200) fails++;
		d = rdata;
		rready <= 1'b0;
		check({30'h0, rresp}, {30'h0, er});
	endtask

	// {carry, value}; imm selects the 5-bit field encodings
	function automatic logic [32:0] shift_model(logic [31:0] s,
		logic [7:0] n, logic [1:0] k, logic imm, logic ci);
		logic [63:0] w;
		int m;
		if (n == 8'h00 && !imm) return {ci, s};
		if (n == 8'h00) begin
			case (k)
				2'h0: return {ci, s};
				2'h1: return {s[31], 32'h0};
				2'h2: return {s[31], {32{s[31]}}};
				default: return {s[0], ci, s[31:1]};
			endcase
		end
		m = n;
		case (k)
			2'h0: begin
				if (m > 32) return 33'h0;
				w = {32'h0, s} << m;
				return {w[32], w[31:0]};
			end
			2'h1: begin
				if (m > 32) return 33'h0;
				w = {s, 32'h0} >> m;
				return {w[31], w[63:32]};
			end
			2'h2: begin
				if (m > 32) m = 32;
				w = 64'($signed({s, 32'h0}) >>> m);
				return {w[31], w[63:32]};
			end
			default: begin
				w = {s, s} >> (m % 32);
				return {w[31], w[31:0]};
			end
		endcase
	endfunction

	task automatic run_one(input int i);
		control_type c;
		logic [31:0] a, s, cnt, st, op2, r, x, y, d;
		logic [63:0] w;
		logic [32:0] sh, sum;
		logic [3:0]  fl, o;
		logic        ci, arith;
		a = xs();
		s = xs();
		st = xs();
		cnt = xs();
		c = control_type'(xs());
		c.opcode = opcode_type'(i % 16);
		c.shift_kind = shift_kind_type'((i / 16) % 4);
		c.reg_shift = ((i / 64) % 3) == 1;
		c.use_imm = ((i / 64) % 3) == 2;
		c.set_flags = (i % 7) != 0;
		c.dest_is_pc = (i % 11) == 0;
		if (i % 5 == 0) c.shift_amount = 5'h00;
		if (i % 3 == 0) cnt[7:0] = cnt_tbl[(i / 3) % 8];
		if (i % 4 == 0) c.imm_rotate = 4'h0;
		if (c.use_imm) begin
			w = {24'h0, c.imm_value, 24'h0, c.imm_value} >> (2 * c.imm_rotate);
			sh = {(c.imm_rotate == 4'h0) ? st[29] : w[31], w[31:0]};
		end else begin
			sh = shift_model(s, c.reg_shift ? cnt[7:0] : {3'h0, c.shift_amount},
				c.shift_kind, !c.reg_shift, st[29]);
		end
		op2 = sh[31:0];
		o = c.opcode;
		arith = 1'b1;
		case (o)
			4'h2, 4'ha: {x, y, ci} = {a, ~op2, 1'b1};
			4'h3: {x, y, ci} = {op2, ~a, 1'b1};
			4'h4, 4'hb: {x, y, ci} = {a, op2, 1'b0};
			4'h5: {x, y, ci} = {a, op2, st[29]};
			4'h6: {x, y, ci} = {a, ~op2, st[29]};
			4'h7: {x, y, ci} = {op2, ~a, st[29]};
			default: {arith, x, y, ci} = {1'b0, a, op2, 1'b0};
		endcase
		sum = {1'b0, x} + {1'b0, y} + {32'h0, ci};
		case (o)
			4'h0, 4'h8: r = a & op2;
			4'h1, 4'h9: r = a ^ op2;
			4'hc: r = a | op2;
			4'hd: r = op2;
			4'he: r = a & ~op2;
			4'hf: r = ~op2;
			default: r = sum[31:0];
		endcase
		fl = st[31:28];
		if (c.set_flags && !c.dest_is_pc)
			fl = {r[31], r == 32'h0, arith ? sum[32] : sh[32],
				arith ? (x[31] == y[31] && r[31] != x[31]) : st[28]};
		if (o[3:2] != 2'b10) exp_res = r;
		wr(OPERAND_ONE_ADDR, a, 4'hf, RESP_OKAY);
		wr(SHIFT_SOURCE_ADDR, s, 4'hf, RESP_OKAY);
		wr(SHIFT_COUNT_ADDR, cnt, 4'hf, RESP_OKAY);
		wr(CONTROL_ADDR, c, 4'hf, RESP_OKAY);
		wr(STATUS_WORD_ADDR, st, 4'hf, RESP_OKAY);
		if (i < 3) begin
			rd(CONTROL_ADDR, d, RESP_OKAY);
			check(d, {5'h0, c[26:0]});
		end
		wr(EXECUTE_ADDR, 32'h1, 4'hf, RESP_OKAY);
		rd(RESULT_ADDR, d, RESP_OKAY);
		check(d, exp_res);
		if (o == 4'hd)
			check(d, op2);
		rd(OUTCOME_ADDR, d, RESP_OKAY);
		check(d, {31'h0, o[3:2] != 2'b10});
		rd(STATUS_WORD_ADDR, d, RESP_OKAY);
		check(d[31:30], fl[3:2]);
		check(d, {fl, 28'h0});
	endtask

	initial begin
		logic [31:0] d;
		repeat (5) @(posedge aclk);
		aresetn <= 1'b1;
		rd(STATUS_WORD_ADDR, d, RESP_OKAY);
		check(d, REG_RESET);
		rd(CONTROL_ADDR, d, RESP_OKAY);
		check(d, REG_RESET);
		rd(RESULT_ADDR, d, RESP_OKAY);
		check(d, REG_RESET);
		// unmapped space and read-only / write-only places
		wr(8'h20, 32'hffff_ffff, 4'hf, RESP_SLVERR);
		rd(8'h20, d, RESP_SLVERR);
		check(d, 32'h0);
		wr(RESULT_ADDR, 32'h1234_5678, 4'hf, RESP_OKAY);
		rd(RESULT_ADDR, d, RESP_OKAY);
		check(d, 32'h0);
		rd(EXECUTE_ADDR, d, RESP_OKAY);
		check(d, 32'h0);
		wr(OPERAND_ONE_ADDR, 32'hffff_ffff, 4'hf, RESP_OKAY);
		wr(OPERAND_ONE_ADDR, 32'h0, 4'h2, RESP_OKAY);
		rd(OPERAND_ONE_ADDR, d, RESP_OKAY);
		check(d, 32'hffff_00ff);
		for (int i = 0; i < 192; i++)
			run_one(i);
		wrap_up();
	end
endmodule
